// ===== rtl/gls_pkg.sv
package gls_pkg;

  // Pin count of the shared general-purpose and LED port.
  localparam int unsigned NUM_PINS = 3;

  // Per-pin configuration codes.
  localparam logic [1:0] MODE_INPUT      = 2'h0;
  localparam logic [1:0] MODE_PUSH_PULL  = 2'h1;
  localparam logic [1:0] MODE_OPEN_DRAIN = 2'h2;

  // Pin positions of the three status LED functions.
  localparam int unsigned PIN_SPEED    = 0;
  localparam int unsigned PIN_LINK_ACT = 1;
  localparam int unsigned PIN_DUPLEX   = 2;

  // Clock and blink timing.
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned BLINK_MS     = 80;
  localparam int unsigned BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_CNT_W  = 24;

  // Reset values.
  localparam logic       XOVER_RESET   = 1'h1;
  localparam logic       PIN_RESET     = 1'h1;

  typedef enum logic [1:0] {
    BLINK_IDLE,
    BLINK_DARK,
    BLINK_LIT
  } gls_blink_e;

endpackage : gls_pkg

// ===== rtl/gls_top.sv
`timescale 1ns/100ps

module gls_top #(
  parameter int unsigned BLINK_CYCLES = gls_pkg::BLINK_CYCLES,
  parameter int unsigned CNT_W        = gls_pkg::BLINK_CNT_W
) (
  // Clock, reset and enable
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic                            clk_en,
  // Software configuration
  input  wire logic [2*gls_pkg::NUM_PINS-1:0] pin_mode,
  input  wire logic [gls_pkg::NUM_PINS-1:0]   pin_out_value,
  input  wire logic [gls_pkg::NUM_PINS-1:0]   pin_led_select,
  output logic      [gls_pkg::NUM_PINS-1:0]   pin_in_value,
  // Link state from the transceiver
  input  wire logic                            link_up,
  input  wire logic                            speed_100,
  input  wire logic                            autoneg_busy,
  input  wire logic                            full_duplex,
  input  wire logic                            tx_activity,
  input  wire logic                            rx_activity,
  // Shared pins
  input  wire logic [gls_pkg::NUM_PINS-1:0]   pin_i,
  output logic      [gls_pkg::NUM_PINS-1:0]   pin_o,
  output logic      [gls_pkg::NUM_PINS-1:0]   pin_oe_n,
  // Crossover strap
  input  wire logic                            auto_crossover_strap,
  output logic                                 auto_crossover_en
);
  import gls_pkg::*;

  // CNT_W must hold BLINK_CYCLES minus one, or the truncated end value would cut every phase short.
  localparam logic [CNT_W-1:0] BLINK_LAST = CNT_W'(BLINK_CYCLES - 1);

  gls_blink_e              blink_q;
  gls_blink_e              blink_d;
  logic [CNT_W-1:0]        blink_cnt_q;
  logic                    pending_q;
  logic                    activity;
  logic                    blink_done;
  logic                    blink_dark;
  logic [NUM_PINS-1:0]     status_led_outputs;
  logic                    speed_indicator;
  logic                    link_activity_indicator;
  logic                    duplex_indicator;
  logic [2:0]              strap_sync_q;
  logic                    xover_q;

  assign activity   = tx_activity | rx_activity;
  assign blink_done = (blink_cnt_q == BLINK_LAST);
  assign blink_dark = (blink_q == BLINK_DARK);

  // Blink sequencer: dark for one period, then lit for at least one period.
  always_comb begin
    blink_d = blink_q;
    unique case (blink_q)
      BLINK_IDLE: begin
        if (link_up && activity) begin
          blink_d = BLINK_DARK;
        end
      end
      BLINK_DARK: begin
        if (blink_done) begin
          blink_d = BLINK_LIT;
        end
      end
      BLINK_LIT: begin
        if (blink_done) begin
          blink_d = (pending_q || activity) ? BLINK_DARK : BLINK_IDLE;
        end
      end
    endcase
    // Losing the link abandons any blink so the pin shows the dropped link at once.
    if (!link_up) begin
      blink_d = BLINK_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      blink_q <= BLINK_IDLE;
    end else if (clk_en) begin
      blink_q <= blink_d;
    end
  end

  // The counter restarts on every state change so each phase lasts a full period.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      blink_cnt_q <= '0;
    end else if (clk_en) begin
      if (blink_d != blink_q || blink_q == BLINK_IDLE) begin
        blink_cnt_q <= '0;
      end else begin
        blink_cnt_q <= blink_cnt_q + CNT_W'(1);
      end
    end
  end

  // Activity seen while the LED is lit is held so it is not lost before the lit phase ends.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pending_q <= 1'h0;
    end else if (clk_en) begin
      if (blink_q == BLINK_LIT && !blink_done) begin
        pending_q <= pending_q | activity;
      end else begin
        pending_q <= 1'h0;
      end
    end
  end

  // Indicators are active low; a released pin lets the board pull-up darken the LED.
  // Speed stays high during negotiation even if a stale speed bit is still set.
  assign speed_indicator         = ~(link_up & speed_100 & ~autoneg_busy);
  assign link_activity_indicator = ~link_up | blink_dark;
  assign duplex_indicator        = ~(link_up & full_duplex);

  // Positions without an indicator stay released.
  always_comb begin
    status_led_outputs               = '1;
    status_led_outputs[PIN_SPEED]    = speed_indicator;
    status_led_outputs[PIN_LINK_ACT] = link_activity_indicator;
    status_led_outputs[PIN_DUPLEX]   = duplex_indicator;
  end

  // Per-pin input filtering and output drive.
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic [2:0] in_sync_q;
    logic       in_q;
    logic [1:0] mode;
    logic       led_sel;
    logic       out_val;

    assign mode    = pin_mode[2*p +: 2];
    assign led_sel = pin_led_select[p];
    assign out_val = pin_out_value[p];

    // Three stages; the first is read only by the second.
    // A one-cycle glitch never passes, since the second and third stages must agree.
    // A pin in any mode still feeds its filter, so software can read back every pin.
    always_ff @(posedge clk) begin
      if (!rstn) begin
        in_sync_q <= {3{PIN_RESET}};
        in_q      <= PIN_RESET;
      end else if (clk_en) begin
        in_sync_q <= {in_sync_q[1:0], pin_i[p]};
        if (in_sync_q[1] == in_sync_q[2]) begin
          in_q <= in_sync_q[2];
        end
      end
    end

    // One more register so the read-back port comes straight from a flip-flop.
    always_ff @(posedge clk) begin
      if (!rstn) begin
        pin_in_value[p] <= PIN_RESET;
      end else if (clk_en) begin
        pin_in_value[p] <= in_q;
      end
    end

    // Open drain holds the data at zero and switches only the enable.
    // The LED function is tested first so software values cannot reach an LED pin.
    always_ff @(posedge clk) begin
      if (!rstn) begin
        pin_o[p]    <= PIN_RESET;
        pin_oe_n[p] <= 1'h1;
      end else if (clk_en) begin
        if (led_sel) begin
          pin_o[p]    <= 1'h0;
          pin_oe_n[p] <= status_led_outputs[p];
        end else if (mode == MODE_PUSH_PULL) begin
          pin_o[p]    <= out_val;
          pin_oe_n[p] <= 1'h0;
        end else if (mode == MODE_OPEN_DRAIN) begin
          pin_o[p]    <= 1'h0;
          pin_oe_n[p] <= out_val;
        end else begin
          // Input mode and the unused code both leave the pin released.
          pin_o[p]    <= PIN_RESET;
          pin_oe_n[p] <= 1'h1;
        end
      end
    end
  end

  // Strap: an open pin floats high through its pull-up, so enabled is the safe default.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strap_sync_q <= {3{XOVER_RESET}};
      xover_q      <= XOVER_RESET;
    end else if (clk_en) begin
      strap_sync_q <= {strap_sync_q[1:0], auto_crossover_strap};
      if (strap_sync_q[1] == strap_sync_q[2]) begin
        xover_q <= strap_sync_q[2];
      end
    end
  end

  // The strap is followed all the time, so a board that moves it late is still honoured.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      auto_crossover_en <= XOVER_RESET;
    end else if (clk_en) begin
      auto_crossover_en <= xover_q;
    end
  end

endmodule : gls_top

// ===== verif/gls_properties.sv
`timescale 1ns/100ps
module gls_checker #(
  parameter int unsigned BLINK_CYCLES = 8
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       clk_en,
  // Configuration and link state
  input wire logic [5:0] pin_mode,
  input wire logic [2:0] pin_out_value,
  input wire logic [2:0] pin_led_select,
  input wire logic       link_up,
  input wire logic       speed_100,
  input wire logic       autoneg_busy,
  input wire logic       full_duplex,
  // Pins and strap
  input wire logic [2:0] pin_i,
  input wire logic [2:0] pin_o,
  input wire logic [2:0] pin_oe_n,
  input wire logic [2:0] pin_in_value,
  input wire logic       auto_crossover_strap,
  input wire logic       auto_crossover_en
);
  import gls_pkg::*;
  logic [2:0] up_q;
  int         hi_q;
  int         lo_q;
  logic       en_q;
  wire        ok = &up_q & en_q;
  // Outputs show reset values one edge after release, so checks start later.
  // An edge with the enable low leaves outputs frozen, so the next edge is not judged.
  always_ff @(posedge clk) begin
    en_q <= clk_en;
    up_q <= rstn ? {up_q[1:0], 1'b1} : 3'h0;
    hi_q <= (!rstn || !pin_oe_n[1]) ? 0 : hi_q + 1;
    lo_q <= (!rstn || pin_oe_n[1]) ? 0 : lo_q + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence steady_s;
    ok && $past(pin_led_select[1] && link_up) && $past(pin_led_select[1] && link_up, 2);
  endsequence
  a_speed_led: assert property (ok && $past(pin_led_select[0]) |-> !pin_o[0] &&
    pin_oe_n[0] == !$past(link_up && speed_100 && !autoneg_busy)) else $error("speed pin wrong");
  a_duplex_led: assert property (ok && $past(pin_led_select[2]) |-> !pin_o[2] &&
    pin_oe_n[2] == !$past(link_up && full_duplex)) else $error("duplex pin wrong");
  a_link_down: assert property (ok && $past(pin_led_select[1] && !link_up) |-> pin_oe_n[1])
    else $error("link pin not released");
  a_dark_len: assert property ($fell(pin_oe_n[1]) ##0 steady_s |-> hi_q == BLINK_CYCLES)
    else $error("dark time wrong");
  a_lit_min: assert property ($rose(pin_oe_n[1]) ##0 steady_s |-> lo_q >= BLINK_CYCLES)
    else $error("lit time short");
  a_push_pull: assert property (ok && $past(!pin_led_select[0] && pin_mode[1:0] == MODE_PUSH_PULL) |->
    !pin_oe_n[0] && pin_o[0] == $past(pin_out_value[0])) else $error("push-pull wrong");
  a_open_drain: assert property (ok && $past(!pin_led_select[0] && pin_mode[1:0] == MODE_OPEN_DRAIN) |->
    !pin_o[0] && pin_oe_n[0] == $past(pin_out_value[0])) else $error("open-drain wrong");
  a_input_rel: assert property (ok && $past(!pin_led_select[0] && pin_mode[1] == pin_mode[0]) |->
    pin_o[0] && pin_oe_n[0]) else $error("input pin driven");
  a_xover_follow: assert property ($stable(auto_crossover_strap)[*8] |=>
    auto_crossover_en == $past(auto_crossover_strap)) else $error("crossover wrong");
  a_in_filter: assert property ($stable(pin_i)[*8] |=> pin_in_value == $past(pin_i))
    else $error("pin input wrong");
endmodule : gls_checker
bind gls_top gls_checker #(.BLINK_CYCLES(BLINK_CYCLES)) chk_u (.clk(clk), .rstn(rstn), .clk_en(clk_en),
  .pin_mode(pin_mode),
  .pin_out_value(pin_out_value), .pin_led_select(pin_led_select), .link_up(link_up), .speed_100(speed_100),
  .autoneg_busy(autoneg_busy), .full_duplex(full_duplex), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
  .pin_in_value(pin_in_value), .auto_crossover_strap(auto_crossover_strap), .auto_crossover_en(auto_crossover_en));

// ===== verif/gls_board_model.sv
`timescale 1ns/100ps
// Pull-up on every pin; the board may pull a released pin low. Contention is not modelled.
module gls_board_model (
  // Device side
  input  wire logic [2:0] pin_o,
  input  wire logic [2:0] pin_oe_n,
  // Board pull-down, active low
  input  wire logic [2:0] board_n,
  // Resolved level
  output logic      [2:0] pin_lvl
);
  always_comb pin_lvl = (pin_o | pin_oe_n) & (board_n | ~pin_oe_n);
endmodule : gls_board_model

// ===== verif/gls_top_tb_top.sv
`timescale 1ns/100ps
module gls_top_tb_top;
  import gls_pkg::*;
  localparam int B = 8;
  logic clk = 0, rstn = 0, link_up = 0, speed_100 = 0, autoneg_busy = 0, full_duplex = 0;
  logic tx_activity = 0, rx_activity = 0, auto_crossover_strap = 1, auto_crossover_en;
  logic [5:0] pin_mode = 0;
  logic [2:0] pin_out_value = 0, pin_led_select = 0, board_n = 7, pin_lvl, pin_o, pin_oe_n, pin_in_value;
  logic [2:0] exp_o, exp_oe, msk;
  logic [31:0] lf = 98844;
  int n_fail = 0, n_checks = 0, i;
  bit live = 0;
  logic clk_en = 1;
  always #5 clk = ~clk;
  gls_top #(.BLINK_CYCLES(B), .CNT_W(24)) dut_u (.clk(clk), .rstn(rstn), .clk_en(clk_en), .pin_mode(pin_mode),
    .pin_out_value(pin_out_value), .pin_led_select(pin_led_select), .pin_in_value(pin_in_value),
    .link_up(link_up), .speed_100(speed_100), .autoneg_busy(autoneg_busy), .full_duplex(full_duplex),
    .tx_activity(tx_activity), .rx_activity(rx_activity), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .auto_crossover_strap(auto_crossover_strap), .auto_crossover_en(auto_crossover_en));
  gls_board_model brd_u (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .board_n(board_n), .pin_lvl(pin_lvl));
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  // Blink phase is not modelled here, so the link pin is masked while its LED function is selected and the link is up.
  always @(posedge clk) begin : ref_b
    logic [2:0] ind;
    ind = {!(link_up && full_duplex), !link_up, !(link_up && speed_100 && !autoneg_busy)};
    if (clk_en) begin
      msk = (pin_led_select[1] && link_up) ? 3'h5 : 3'h7;
      for (int p = 0; p < 3; p++) begin
        case (pin_mode[2*p+:2])
          MODE_PUSH_PULL:  {exp_o[p], exp_oe[p]} = {pin_out_value[p], 1'b0};
          MODE_OPEN_DRAIN: {exp_o[p], exp_oe[p]} = {1'b0, pin_out_value[p]};
          default:         {exp_o[p], exp_oe[p]} = 2'h3;
        endcase
        if (pin_led_select[p]) {exp_o[p], exp_oe[p]} = {1'b0, ind[p]};
      end
    end
  end
  always @(negedge clk) if (live) begin
    chk("pin_o", exp_o & msk, pin_o & msk);
    chk("pin_oe_n", exp_oe & msk, pin_oe_n & msk);
  end
  task automatic blink(logic lvl, int n, int e);
    int c;
    c = 0;
    @(posedge clk) {tx_activity, rx_activity} <= {1'b1, lvl};
    @(posedge clk) tx_activity <= 0;
    repeat (n) @(negedge clk) c += pin_oe_n[1];
    chk("blink_high", e, c);
    @(posedge clk) rx_activity <= 0;
    repeat (3*B) @(posedge clk);
  endtask : blink
  initial begin #500000; n_fail++; end_sim(); end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    live = 1;
    repeat (300) begin
      @(posedge clk);
      lf = nxt(lf);
      {pin_mode, pin_out_value, pin_led_select, link_up, speed_100, autoneg_busy, full_duplex, board_n} <= lf[18:0];
    end
    @(posedge clk) {pin_led_select, link_up} <= 4'h5;
    repeat (3*B) @(posedge clk);
    @(negedge clk) chk("lit", 3'h0, pin_oe_n & 3'h2);
    blink(0, 3*B, B);
    blink(1, 4*B, 2*B);
    for (i = 0; i < 2; i++) begin
      @(posedge clk) {auto_crossover_strap, pin_mode, pin_led_select, board_n} <= {i[0], 9'h0, {3{i[0]}}};
      repeat (10) @(posedge clk);
      @(negedge clk) chk("xover", i[0], auto_crossover_en);
      chk("pin_in", {3{i[0]}}, pin_in_value);
    end
    @(posedge clk) {pin_mode, pin_out_value} <= 9'h009;
    repeat (3) @(posedge clk);
    @(posedge clk) clk_en <= 0;
    @(posedge clk) pin_out_value <= 3'h0;
    repeat (4) @(posedge clk);
    @(negedge clk) chk("frozen", 1, pin_o[0]);
    @(posedge clk) clk_en <= 1;
    repeat (2) @(posedge clk);
    @(negedge clk) chk("thawed", 0, pin_o[0]);
    end_sim();
  end
endmodule : gls_top_tb_top
